/* bench/wcrc_ctrl_model.sv */
// Controller model driving write bursts
`timescale 1ns/1ps
module wcrc_ctrl_model (
	output logic data_strobe,
	output logic [15:0] dq,
	output logic lower_lane_invert_flag,
	output logic upper_lane_invert_flag,
	output logic burst_start,
	output logic burst_chop_four,
	output logic addr_a2
);
	initial begin
		data_strobe = 1'h0;
		dq = 16'h0000;
		lower_lane_invert_flag = 1'h1;
		upper_lane_invert_flag = 1'h1;
		burst_start = 1'h0;
		burst_chop_four = 1'h0;
		addr_a2 = 1'h0;
	end
	// ==========
	// One burst of ten transfers, strobe still afterwards
	task send(input logic [159:0] d, input logic [19:0] f, input logic bc, input logic a2);
		#13;
		burst_chop_four = bc;
		addr_a2 = a2;
		burst_start = 1'h1;
		#200;
		for (int t = 0; t < 10; t++) begin
			dq = d[t*16 +: 16];
			lower_lane_invert_flag = f[t*2];
			upper_lane_invert_flag = f[t*2+1];
			#50;
			data_strobe = ~data_strobe;
			#110;
		end
		dq = ~dq;
		lower_lane_invert_flag = ~lower_lane_invert_flag;
		upper_lane_invert_flag = ~upper_lane_invert_flag;
		burst_start = 1'h0;
		#300;
	endtask
endmodule

/* bench/wcrc_top_properties.sv */
// Port checks for the write CRC block
`timescale 1ns/1ps
module wcrc_top_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic command_parity_check,
	input wire logic alert_n_o,
	input wire logic alert_n_oe,
	input wire logic wr_valid
);
	logic [3:0] low_q;
	logic err_q;
	logic mask_q;
	wire acc = psel && penable;
	wire rd_acc = acc && !pwrite;
	wire crc_low = alert_n_oe && !command_parity_check;
	wire clr_wr = acc && pwrite && paddr == 32'h4 && !pwdata[3];
	// ==========
	// Pulse length and sticky error shadow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q <= 4'h0;
			err_q <= 1'h0;
			mask_q <= 1'h0;
		end else begin
			low_q <= crc_low ? low_q + 4'h1 : 4'h0;
			err_q <= (crc_low && low_q == 4'h0) || (err_q && !clr_wr);
			if (acc && pwrite && paddr == 32'h0) begin
				mask_q <= pwdata[2];
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// Assertions and covers
	a_parity_shared: assert property (command_parity_check |-> alert_n_oe)
		else $error("alert not driven during parity error");
	a_pulse_width: assert property (disable iff (!presetn || command_parity_check)
		$rose(alert_n_oe) |-> alert_n_oe[*8] ##1 !alert_n_oe[*2])
		else $error("alert pulse width wrong");
	a_pulse_max: assert property (low_q <= 4'ha)
		else $error("alert low too long");
	a_drive_level: assert property (alert_n_o == 1'h0)
		else $error("alert driven high");
	a_alert_cause: assert property ($rose(crc_low) |->
		wr_valid || mask_q || $past(crc_low, 4))
		else $error("alert without a write");
	a_valid_single: assert property (wr_valid |=> !wr_valid)
		else $error("write pulse too long");
	a_status_read: assert property (rd_acc && paddr == 32'h4 |-> prdata[3] == err_q)
		else $error("status error bit wrong");
	a_log_read: assert property (rd_acc && paddr == 32'h8 |-> prdata[7] == err_q)
		else $error("log flag wrong");
	a_ready_zero: assert property (acc |-> pready)
		else $error("no ready in access");
	a_unmapped: assert property (acc && paddr > 32'hc |-> pslverr)
		else $error("no error on unmapped access");
	c_crc_alert: cover property ($rose(crc_low));
	c_write: cover property (wr_valid);
	c_slverr: cover property (acc && pslverr);
endmodule
bind wcrc_top wcrc_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .command_parity_check, .alert_n_o, .alert_n_oe, .wr_valid);

/* bench/wcrc_top_tb.sv */
// Self-checking bench for the write CRC block
`timescale 1ns/1ps
module wcrc_top_tb;
	import wcrc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, seed;
	logic data_strobe, lower_lane_invert_flag, upper_lane_invert_flag;
	logic burst_start, burst_chop_four, addr_a2, command_parity_check;
	logic alert_n_o, alert_n_oe, wr_valid;
	logic [15:0] dq, wr_mask;
	logic [127:0] wr_data;
	logic [144:0] exp_q[$];
	logic [144:0] mon_n;
	logic inv_on, mask_on;
	int err_total, checks;
	wcrc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .data_strobe, .dq, .lower_lane_invert_flag, .upper_lane_invert_flag,
		.burst_start, .burst_chop_four, .addr_a2, .command_parity_check, .alert_n_o,
		.alert_n_oe, .wr_data, .wr_mask, .wr_valid);
	wcrc_ctrl_model ctl (.data_strobe, .dq, .lower_lane_invert_flag, .upper_lane_invert_flag,
		.burst_start, .burst_chop_four, .addr_a2);
	// ==========
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] crc8(input logic [71:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--)
			c = {c[6:0], 1'h0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	function automatic logic [71:0] vect(input logic [159:0] d, input logic [19:0] f,
		input int g, input logic bc, input logic a2);
		logic [71:0] v;
		int t;
		for (int l = 0; l < 9; l++)
			for (int p = 0; p < 8; p++) begin
				t = (bc && a2) ? p - 4 : p;
				if (bc && (t < 0 || t > 3)) v[l*8+p] = 1'h1;
				else v[l*8+p] = (l < 8) ? d[t*16+g*8+l] : f[t*2+g];
			end
		return v;
	endfunction
	task chk(input string n, input logic [127:0] s, input logic [127:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic s);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		s = pslverr;
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		logic s;
		apb(1'h0, a, 32'h0, r, s);
		chk("prdata", r, e);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic s;
		apb(1'h1, a, d, r, s);
	endtask
	task burst(input logic bad, input logic bc, input logic a2);
		logic [159:0] d;
		logic [19:0] f;
		logic [144:0] n;
		d = {rnd(), rnd(), rnd(), rnd(), rnd()};
		f = 20'(rnd());
		d[159:128] = 32'hffff_ffff;
		f[19:16] = 4'hf;
		for (int g = 0; g < 2; g++)
			d[128+g*8 +: 8] = crc8(vect(d, f, g, bc, a2)) ^ {7'h0, bad && g == 0};
		n[128] = bc;
		n[144:129] = mask_on ? ~f[15:0] : 16'h0;
		for (int i = 0; i < 16; i++)
			n[i*8 +: 8] = d[i*8 +: 8] ^ {8{inv_on & ~f[i]}};
		// Masked bursts with a bad CRC are never written
		if (!(bad && mask_on)) exp_q.push_back(n);
		ctl.send(d, f, bc, a2);
		for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge pclk);
		chk("pending writes", exp_q.size(), 0);
		repeat (14) @(posedge pclk);
	endtask
	task final_report;
		$display("mismatches %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========
	// Clock, monitor, watchdog
	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end
	always @(negedge pclk) begin
		if (wr_valid === 1'h1) begin
			if (exp_q.size() == 0) chk("unexpected write", 1, 0);
			else begin
				mon_n = exp_q.pop_front();
				chk("wr_data", mon_n[128] ? wr_data[63:0] : wr_data, mon_n[128] ? mon_n[63:0] : mon_n[127:0]);
				chk("wr_mask", wr_mask, mon_n[144:129]);
			end
		end
	end
	initial begin
		#400000;
		err_total++;
		final_report;
	end
	// ==========
	// Main sequence
	initial begin
		logic [31:0] r;
		logic s;
		{psel, penable, pwrite, presetn, command_parity_check} = 5'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		seed = 32'h05a4;
		{inv_on, mask_on} = 2'h2;
		err_total = 0;
		checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		rd(WCRC_CTRL_OFS, WCRC_CTRL_RST);
		rd(WCRC_STATUS_OFS, 32'h0);
		rd(WCRC_LOG_OFS, 32'h0);
		apb(1'h0, 8'h10, 32'h0, r, s);
		chk("unmapped", {s, r}, {1'h1, 32'h0});
		wr(WCRC_CTRL_OFS, 32'h13);
		rd(WCRC_CTRL_OFS, 32'h13);
		command_parity_check <= 1'h1;
		repeat (50) @(posedge pclk);
		command_parity_check <= 1'h0;
		burst(1'h0, 1'h0, 1'h0);
		burst(1'h1, 1'h0, 1'h0);
		rd(WCRC_STATUS_OFS, 32'h8);
		rd(WCRC_LOG_OFS, 32'h80);
		rd(WCRC_ERRCNT_OFS, 32'h1);
		burst(1'h0, 1'h0, 1'h0);
		burst(1'h1, 1'h0, 1'h0);
		rd(WCRC_ERRCNT_OFS, 32'h2);
		wr(WCRC_STATUS_OFS, 32'h8);
		rd(WCRC_STATUS_OFS, 32'h8);
		wr(WCRC_STATUS_OFS, 32'h0);
		rd(WCRC_STATUS_OFS, 32'h0);
		rd(WCRC_LOG_OFS, 32'h0);
		for (int a = 0; a < 2; a++)
			burst(1'h0, 1'h1, 1'(a));
		rd(WCRC_ERRCNT_OFS, 32'h2);
		wr(WCRC_CTRL_OFS, 32'h12);
		burst(1'h1, 1'h0, 1'h0);
		rd(WCRC_ERRCNT_OFS, 32'h2);
		wr(WCRC_CTRL_OFS, 32'h0d);
		{inv_on, mask_on} = 2'h1;
		burst(1'h0, 1'h0, 1'h0);
		burst(1'h1, 1'h0, 1'h0);
		rd(WCRC_ERRCNT_OFS, 32'h3);
		rd(WCRC_STATUS_OFS, 32'h8);
		final_report;
	end
endmodule

/* src/wcrc_alert.sv */
// Short low pulse generator for the shared alert line
`timescale 1ns/1ps
module wcrc_alert (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic err_evt,
	output logic drive_low,
	output logic busy
);
	import wcrc_pkg::*;

	typedef enum logic [2:0] {
		WCRC_AL_IDLE = 3'b001,
		WCRC_AL_LOW = 3'b010,
		WCRC_AL_GAP = 3'b100
	} wcrc_al_e;

	wcrc_al_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [3:0] pend_q, pend_d;
	logic take;
	logic pend_inc;

	// ==========================================================
	// Each detected error queues its own pulse while fewer than WCRC_PEND_MAX are pending
	assign take = (st_q == WCRC_AL_IDLE) && (pend_q != 4'h0 || err_evt);
	assign pend_inc = err_evt && pend_q != WCRC_PEND_MAX;
	assign pend_d = pend_q + {3'h0, pend_inc} - {3'h0, take};
	assign drive_low = (st_q == WCRC_AL_LOW);
	assign busy = (st_q != WCRC_AL_IDLE) || (pend_q != 4'h0);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			WCRC_AL_IDLE: begin
				if (take) begin
					st_d = WCRC_AL_LOW;
					cnt_d = WCRC_ALERT_PULSE_WIDTH_CYC - 4'h1;
				end
			end
			WCRC_AL_LOW: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					st_d = WCRC_AL_GAP;
					cnt_d = WCRC_ALERT_GAP_CYC - 4'h1;
				end
			end
			WCRC_AL_GAP: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					st_d = WCRC_AL_IDLE;
				end
			end
			default: begin
				st_d = WCRC_AL_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= WCRC_AL_IDLE;
			cnt_q <= 4'h0;
			pend_q <= 4'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
		end
	end
endmodule

/* src/wcrc_pkg.sv */
// Shared constants for the write CRC check and bus inversion block
package wcrc_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] WCRC_CTRL_OFS = 8'h00;
	localparam logic [7:0] WCRC_STATUS_OFS = 8'h04;
	localparam logic [7:0] WCRC_LOG_OFS = 8'h08;
	localparam logic [7:0] WCRC_ERRCNT_OFS = 8'h0c;
	// Control fields
	localparam int WCRC_CTRL_CRC_EN = 0;
	localparam int WCRC_CTRL_WINV_EN = 1;
	localparam int WCRC_CTRL_MASK_EN = 2;
	localparam int WCRC_CTRL_ORG_LSB = 3;
	localparam logic [31:0] WCRC_CTRL_RST = 32'h0000_0011;
	// Status and log fields
	localparam int WCRC_STATUS_ERR = 3;
	localparam int WCRC_STATUS_BUSY = 4;
	localparam int WCRC_LOG_ERR = 7;
	// ==========================================================
	// Organisations
	localparam logic [1:0] WCRC_ORG_X4 = 2'h0;
	localparam logic [1:0] WCRC_ORG_X8 = 2'h1;
	localparam logic [1:0] WCRC_ORG_X16 = 2'h2;
	// ==========================================================
	// Burst and CRC shape
	localparam int WCRC_LANES = 16;
	localparam int WCRC_GROUPS = 2;
	localparam int WCRC_VEC_W = 72;
	localparam logic [3:0] WCRC_BURST_LEN = 4'h8;
	localparam logic [3:0] WCRC_BURST_CRC_LEN = 4'ha;
	localparam logic [7:0] WCRC_POLY = 8'h07;
	localparam logic [7:0] WCRC_INIT = 8'h00;
	// ==========================================================
	// Alert timing in device clocks
	localparam int WCRC_ALERT_MAX_CLK = 10;
	localparam logic [3:0] WCRC_ALERT_PULSE_WIDTH_CYC = 4'h8;
	localparam logic [3:0] WCRC_ALERT_GAP_CYC = 4'h2;
	localparam logic [3:0] WCRC_PEND_MAX = 4'hf;
endpackage

/* src/wcrc_top.sv */
// Write CRC check, error reporting and write bus inversion
`timescale 1ns/1ps
module wcrc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic data_strobe,
	input wire logic [15:0] dq,
	input wire logic lower_lane_invert_flag,
	input wire logic upper_lane_invert_flag,
	input wire logic burst_start,
	input wire logic burst_chop_four,
	input wire logic addr_a2,
	input wire logic command_parity_check,
	output logic alert_n_o,
	output logic alert_n_oe,
	output logic [127:0] wr_data,
	output logic [15:0] wr_mask,
	output logic wr_valid
);
	import wcrc_pkg::*;

	typedef enum logic [2:0] {
		WCRC_IDLE = 3'b001,
		WCRC_CAPT = 3'b010,
		WCRC_CHECK = 3'b100
	} wcrc_st_e;

	localparam int SYNC_W = 22;

	// ==========================================================
	// Input synchronisers
	logic [SYNC_W-1:0] sync1_q, sync2_q;
	logic dqs_prev_q, start_prev_q;
	logic [SYNC_W-1:0] pins;
	logic dqs_s, start_s, bc4_s, a2_s;
	logic [15:0] dq_s;
	logic [1:0] flg_s;
	logic dqs_edge, start_rise;

	assign pins = {addr_a2, burst_chop_four, burst_start, data_strobe,
		upper_lane_invert_flag, lower_lane_invert_flag, dq};
	assign dq_s = sync2_q[15:0];
	assign flg_s = sync2_q[17:16];
	assign dqs_s = sync2_q[18];
	assign start_s = sync2_q[19];
	assign bc4_s = sync2_q[20];
	assign a2_s = sync2_q[21];
	assign dqs_edge = dqs_s ^ dqs_prev_q;
	assign start_rise = start_s & ~start_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			dqs_prev_q <= 1'b0;
			start_prev_q <= 1'b0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			dqs_prev_q <= dqs_s;
			start_prev_q <= start_s;
		end
	end

	// ==========================================================
	// Register file
	logic [31:0] ctrl_q;
	logic sticky_q, sticky_d;
	logic log_q, log_d;
	logic [7:0] errcnt_q;
	logic acc, wr_acc;
	logic sel_ctrl, sel_status, sel_log, sel_cnt, mapped;
	logic crc_en, winv_en, mask_en;
	logic [1:0] org;
	logic err_evt, alert_busy;
	logic clr_req;
	logic [31:0] rd_mux;

	assign acc = psel & penable;
	assign wr_acc = acc & pwrite;
	assign sel_ctrl = paddr[7:0] == WCRC_CTRL_OFS;
	assign sel_status = paddr[7:0] == WCRC_STATUS_OFS;
	assign sel_log = paddr[7:0] == WCRC_LOG_OFS;
	assign sel_cnt = paddr[7:0] == WCRC_ERRCNT_OFS;
	assign mapped = (paddr[31:8] == 24'h0) & (sel_ctrl | sel_status | sel_log | sel_cnt);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	assign crc_en = ctrl_q[WCRC_CTRL_CRC_EN];
	assign winv_en = ctrl_q[WCRC_CTRL_WINV_EN];
	assign mask_en = ctrl_q[WCRC_CTRL_MASK_EN];
	assign org = ctrl_q[WCRC_CTRL_ORG_LSB +: 2];

	// Mode-set write of zero to the error bit
	assign clr_req = wr_acc & sel_status & mapped & ~pwdata[WCRC_STATUS_ERR];
	assign sticky_d = err_evt | (sticky_q & ~clr_req);
	assign log_d = sticky_d;

	always_comb begin
		rd_mux = 32'h0;
		if (sel_ctrl) begin
			rd_mux = ctrl_q;
		end else if (sel_status) begin
			rd_mux[WCRC_STATUS_ERR] = sticky_q;
			rd_mux[WCRC_STATUS_BUSY] = alert_busy;
		end else if (sel_log) begin
			rd_mux[WCRC_LOG_ERR] = log_q;
		end else if (sel_cnt) begin
			rd_mux[7:0] = errcnt_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= WCRC_CTRL_RST;
			prdata <= 32'h0;
		end else begin
			if (wr_acc & sel_ctrl & mapped) begin
				ctrl_q <= {27'h0, pwdata[4:0]};
			end
			if (psel & ~penable & ~pwrite) begin
				prdata <= mapped ? rd_mux : 32'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_q <= 1'b0;
			log_q <= 1'b0;
			errcnt_q <= 8'h0;
		end else begin
			sticky_q <= sticky_d;
			log_q <= log_d;
			if (err_evt && errcnt_q != 8'hff) begin
				errcnt_q <= errcnt_q + 8'h1;
			end
		end
	end

	// ==========================================================
	// Burst capture on both strobe edges
	wcrc_st_e st_q, st_d;
	logic [3:0] cnt_q;
	logic [3:0] burst_len;
	logic bc4_q, a2_q;
	logic [15:0] dq_cap_q [0:9];
	logic [1:0] flg_cap_q [0:9];
	logic last_xfer;

	assign burst_len = crc_en ? WCRC_BURST_CRC_LEN : WCRC_BURST_LEN;
	assign last_xfer = dqs_edge && (cnt_q == burst_len - 4'h1);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			WCRC_IDLE: begin
				if (start_rise) begin
					st_d = WCRC_CAPT;
				end
			end
			WCRC_CAPT: begin
				if (last_xfer) begin
					st_d = WCRC_CHECK;
				end
			end
			WCRC_CHECK: begin
				st_d = WCRC_IDLE;
			end
			default: begin
				st_d = WCRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= WCRC_IDLE;
			cnt_q <= 4'h0;
			bc4_q <= 1'b0;
			a2_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_q == WCRC_IDLE && start_rise) begin
				cnt_q <= 4'h0;
				bc4_q <= bc4_s;
				a2_q <= a2_s;
			end else if (st_q == WCRC_CAPT && dqs_edge) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 10; i++) begin
				dq_cap_q[i] <= 16'h0;
				flg_cap_q[i] <= 2'h3;
			end
		end else if (st_q == WCRC_CAPT && dqs_edge) begin
			dq_cap_q[cnt_q] <= dq_s;
			flg_cap_q[cnt_q] <= flg_s;
		end
	end

	// ==========================================================
	// CRC tree inputs
	wcrc_tree_if tif0 ();
	wcrc_tree_if tif1 ();
	logic [71:0] vec [0:1];
	logic [7:0] crc_rx [0:1];
	logic mask_lane_used;

	// Mask lane counts only when mask or inversion is on
	assign mask_lane_used = (mask_en | winv_en) & (org != WCRC_ORG_X4);

	always_comb begin
		logic lane_used;
		logic pos_used;
		logic [2:0] src;
		lane_used = 1'b0;
		pos_used = 1'b0;
		src = 3'h0;
		for (int g = 0; g < WCRC_GROUPS; g++) begin
			for (int l = 0; l < 9; l++) begin
				for (int p = 0; p < 8; p++) begin
					// A2 picks which half of the chopped vector holds data
					pos_used = !bc4_q || (p[2] == a2_q);
					src = bc4_q ? {1'b0, p[1:0]} : p[2:0];
					if (l == 8) begin
						lane_used = mask_lane_used;
					end else if (org == WCRC_ORG_X4) begin
						lane_used = (g == 0) && (l < 4);
					end else begin
						lane_used = 1'b1;
					end
					if (lane_used && pos_used) begin
						vec[g][l*8+p] = (l == 8) ? flg_cap_q[src][g] : dq_cap_q[src][g*8+l];
					end else begin
						vec[g][l*8+p] = 1'b1;
					end
				end
			end
			if (org == WCRC_ORG_X4) begin
				crc_rx[g] = {dq_cap_q[9][3:0], dq_cap_q[8][3:0]};
			end else begin
				crc_rx[g] = dq_cap_q[8][g*8 +: 8];
			end
		end
	end

	assign tif0.vec = vec[0];
	assign tif0.crc_rx = crc_rx[0];
	assign tif1.vec = vec[1];
	assign tif1.crc_rx = crc_rx[1];

	wcrc_tree u_tree0 (
		.t(tif0)
	);

	wcrc_tree u_tree1 (
		.t(tif1)
	);

	assign err_evt = (st_q == WCRC_CHECK) && crc_en &&
		(tif0.mismatch || (org == WCRC_ORG_X16 && tif1.mismatch));

	// ==========================================================
	// Alert line
	logic crc_low;

	wcrc_alert u_alert (
		.pclk(pclk),
		.presetn(presetn),
		.err_evt(err_evt),
		.drive_low(crc_low),
		.busy(alert_busy)
	);

	assign alert_n_o = 1'b0;
	assign alert_n_oe = crc_low | command_parity_check;

	// ==========================================================
	// Stored write data with inversion and mask
	logic inv_allowed;
	logic [127:0] data_d;
	logic [15:0] mask_d;

	assign inv_allowed = winv_en & (org != WCRC_ORG_X4);

	always_comb begin
		for (int t = 0; t < 8; t++) begin
			for (int g = 0; g < WCRC_GROUPS; g++) begin
				// Active low flag means the lane arrived inverted
				data_d[t*16+g*8 +: 8] = dq_cap_q[t][g*8 +: 8] ^
					{8{inv_allowed & ~flg_cap_q[t][g]}};
				mask_d[t*2+g] = mask_en & ~inv_allowed & ~flg_cap_q[t][g];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_data <= 128'h0;
			wr_mask <= 16'h0;
			wr_valid <= 1'b0;
		end else begin
			// Masked bursts with a bad CRC are dropped
			wr_valid <= (st_q == WCRC_CHECK) && !(err_evt && mask_en);
			if (st_q == WCRC_CHECK) begin
				wr_data <= data_d;
				wr_mask <= mask_d;
			end
		end
	end
endmodule

/* src/wcrc_tree.sv */
// One CRC-8 tree over a 72-bit burst vector
`timescale 1ns/1ps
module wcrc_tree (
	wcrc_tree_if.tree t
);
	import wcrc_pkg::*;

	// ==========================================================
	// Serial form of the tree, highest input bit first
	function automatic logic [7:0] crc8(input logic [71:0] v);
		logic [7:0] c;
		logic fb;
		c = WCRC_INIT;
		for (int i = WCRC_VEC_W - 1; i >= 0; i--) begin
			fb = c[7] ^ v[i];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ WCRC_POLY;
			end
		end
		return c;
	endfunction

	assign t.crc_calc = crc8(t.vec);
	assign t.mismatch = (t.crc_calc != t.crc_rx);
endmodule

/* src/wcrc_tree_if.sv */
// Link between the burst capture logic and one CRC tree
`timescale 1ns/1ps
interface wcrc_tree_if;
	logic [71:0] vec;
	logic [7:0] crc_rx;
	logic [7:0] crc_calc;
	logic mismatch;
	modport src (output vec, output crc_rx, input crc_calc, input mismatch);
	modport tree (input vec, input crc_rx, output crc_calc, output mismatch);
endinterface
